/* hdl/param_rounder.v */
// rounds a requested parameter to the supported grid
`timescale 1ns/100ps
module param_rounder #(
  parameter W = 8,
  parameter STEP_LOG2 = 2
) (
  input wire [W-1:0] value_i,
  input wire is_max_i,
  output wire exact_o,
  output wire [W-1:0] rounded_o
);
  wire [W-1:0] down;
  wire [W-1:0] up;
  assign down = {value_i[W-1:STEP_LOG2], {STEP_LOG2{1'b0}}};
  // a max field goes down, a min field goes up; saturate at top of range
  assign up = (&value_i[W-1:STEP_LOG2]) ? down :
              down + {{(W-STEP_LOG2-1){1'b0}}, 1'b1, {STEP_LOG2{1'b0}}};
  assign exact_o = (value_i[STEP_LOG2-1:0] == {STEP_LOG2{1'b0}});
  assign rounded_o = exact_o ? value_i : (is_max_i ? down : up);
endmodule

/* hdl/task_queue_ctrl.v */
// task queue, ordering, reset sequencing and parameter checks of a target
`timescale 1ns/100ps
`include "task_queue_defines.vh"
module task_queue_ctrl #(
  parameter DEPTH = 8,
  parameter IDX_W = 3,
  parameter INIT_N = 4,
  parameter INIT_W = 2,
  parameter TAG_W = 8,
  parameter NEST_N = 2
) (
  input wire clk_i,
  input wire arst_n_i,
  // register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // new task arriving from an initiator
  input wire cmd_valid_i,
  input wire [INIT_W-1:0] cmd_init_i,
  input wire [1:0] cmd_attr_i,
  input wire [TAG_W-1:0] cmd_tag_i,
  input wire cmd_disc_i,
  input wire cmd_clears_ua_i,
  input wire cmd_has_param_i,
  input wire [7:0] cmd_param_i,
  input wire cmd_param_max_i,
  input wire cmd_param_round_ok_i,
  input wire cmd_check_i,
  output reg resp_valid_o,
  output reg [7:0] resp_status_o,
  output reg [INIT_W-1:0] resp_init_o,
  output reg [7:0] resp_param_o,
  // dispatch to the execution engine
  output wire exec_valid_o,
  input wire exec_ready_i,
  output reg [INIT_W-1:0] exec_init_o,
  output reg [TAG_W-1:0] exec_tag_o,
  output reg exec_tagged_o,
  input wire exec_done_i,
  output reg exec_abort_o,
  // deferred error report
  input wire deferred_err_i,
  input wire [INIT_W-1:0] deferred_init_i,
  output reg deferred_valid_o,
  output reg [INIT_W-1:0] deferred_init_o,
  output reg [TAG_W-1:0] deferred_tag_o,
  // reset of nested logical units
  output reg nested_reset_o,
  output wire queue_full_o
);
  // ************************************************************
  // state
  // ************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_ABORT = 2'h1;
  localparam ST_MODE = 2'h2;
  localparam ST_FINISH = 2'h3;

  reg [1:0] st_q;
  reg tagged_mode_q;
  reg mode_saved_valid_q;
  reg [7:0] mode_cur_q;
  reg [7:0] mode_saved_q;
  reg [7:0] mode_default_q;
  reg [INIT_N-1:0] ua_q;
  reg [INIT_N-1:0] resv_q;
  reg ca_q;
  reg [INIT_W-1:0] ca_init_q;
  reg [3:0] sense_key_q;
  reg [7:0] sense_asc_q;
  reg [INIT_W-1:0] sense_init_q;
  reg [7:0] param_last_q;
  reg busy_exec_q;
  reg [INIT_W-1:0] run_init_q;

  reg [DEPTH-1:0] v_q;
  reg [INIT_W-1:0] qi_q [0:DEPTH-1];
  reg [TAG_W-1:0] qt_q [0:DEPTH-1];
  reg [1:0] qa_q [0:DEPTH-1];
  reg [IDX_W:0] cnt_q;

  integer k;
  integer m;
  reg [INIT_N-1:0] has_tagged;
  reg [INIT_N-1:0] has_untagged;
  always @* begin
    has_tagged = {INIT_N{1'b0}};
    has_untagged = {INIT_N{1'b0}};
    for (k = 0; k < DEPTH; k = k + 1) begin
      if (v_q[k]) begin
        if (qa_q[k] == `TQ_ATTR_UNTAGGED) begin
          has_untagged[qi_q[k]] = 1'b1;
        end else begin
          has_tagged[qi_q[k]] = 1'b1;
        end
      end
    end
  end

  assign queue_full_o = (cnt_q == DEPTH[IDX_W:0]);

  // ************************************************************
  // command admission
  // ************************************************************
  wire untag = (cmd_attr_i == `TQ_ATTR_UNTAGGED);
  wire in_reset = (st_q != ST_IDLE);
  wire [INIT_N-1:0] ini_bit = {{(INIT_N-1){1'b0}}, 1'b1} << cmd_init_i;
  wire running_same = busy_exec_q && (run_init_q == cmd_init_i);
  wire overlap = cmd_valid_i && !in_reset &&
                 ((untag && |(has_tagged & ini_bit) && !ca_q) ||
                  (!untag && |(has_untagged & ini_bit)));
  wire dup_untag = untag && (|(has_untagged & ini_bit) || running_same);
  wire ca_block = ca_q && (cmd_init_i != ca_init_q);
  wire busy = in_reset || ca_block || !cmd_disc_i || queue_full_o ||
              (!tagged_mode_q && !untag) || (dup_untag && !overlap);

  wire p_exact;
  wire [7:0] p_round;
  param_rounder #(
    .W(8),
    .STEP_LOG2(2)
  ) u_round (
    .value_i(cmd_param_i),
    .is_max_i(cmd_param_max_i),
    .exact_o(p_exact),
    .rounded_o(p_round)
  );
  wire round_en = mode_cur_q[`TQ_MODE_ROUND_BIT] && cmd_param_round_ok_i;
  wire p_bad = cmd_has_param_i && !p_exact;
  wire accept = cmd_valid_i && !busy && !overlap && !(p_bad && !round_en);

  // ************************************************************
  // dispatch selection
  // ************************************************************
  // queue is kept compacted in arrival order; slot 0 is next. head
  // commands push at the front so a run of them comes out LIFO.
  // simple commands are kept in order too, which honours every fence.
  // order preserved
  wire can_issue = v_q[0] && !busy_exec_q && !ca_q && !in_reset;
  assign exec_valid_o = can_issue;
  wire issue = can_issue && exec_ready_i;

  // ************************************************************
  // sequential
  // ************************************************************
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `TQ_ADDR_CTRL);
  wire hard_rst = wr_ctrl && reg_wdata_i[`TQ_CTRL_HARD_RST];
  wire lu_rst = wr_ctrl && reg_wdata_i[`TQ_CTRL_LU_RST];
  wire ua_clr = accept && cmd_clears_ua_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= ST_IDLE;
      tagged_mode_q <= 1'b0;
      mode_saved_valid_q <= 1'b0;
      mode_cur_q <= `TQ_MODE_RESET;
      mode_saved_q <= `TQ_MODE_RESET;
      mode_default_q <= `TQ_MODE_RESET;
      ua_q <= {INIT_N{1'b1}};
      resv_q <= {INIT_N{1'b0}};
      ca_q <= 1'b0;
      ca_init_q <= {INIT_W{1'b0}};
      sense_key_q <= `TQ_KEY_NONE;
      sense_asc_q <= `TQ_ASC_NONE;
      sense_init_q <= {INIT_W{1'b0}};
      param_last_q <= 8'h00;
      busy_exec_q <= 1'b0;
      run_init_q <= {INIT_W{1'b0}};
      v_q <= {DEPTH{1'b0}};
      cnt_q <= {(IDX_W+1){1'b0}};
      resp_valid_o <= 1'b0;
      resp_status_o <= `TQ_STAT_GOOD;
      resp_init_o <= {INIT_W{1'b0}};
      resp_param_o <= 8'h00;
      exec_init_o <= {INIT_W{1'b0}};
      exec_tag_o <= {TAG_W{1'b0}};
      exec_tagged_o <= 1'b0;
      exec_abort_o <= 1'b0;
      deferred_valid_o <= 1'b0;
      deferred_init_o <= {INIT_W{1'b0}};
      deferred_tag_o <= {TAG_W{1'b0}};
      nested_reset_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
      for (m = 0; m < DEPTH; m = m + 1) begin
        qi_q[m] <= {INIT_W{1'b0}};
        qt_q[m] <= {TAG_W{1'b0}};
        qa_q[m] <= 2'h0;
      end
    end else begin
      resp_valid_o <= 1'b0;
      exec_abort_o <= 1'b0;
      nested_reset_o <= 1'b0;
      deferred_valid_o <= 1'b0;

      // register writes
      if (reg_wr_i) begin
        case (reg_addr_i)
          `TQ_ADDR_CTRL: begin
            tagged_mode_q <= reg_wdata_i[`TQ_CTRL_TAGGED];
            mode_saved_valid_q <= reg_wdata_i[`TQ_CTRL_MODE_SAVED_VALID];
            if (reg_wdata_i[`TQ_CTRL_CA_CLEAR]) begin
              ca_q <= 1'b0;
            end
          end
          `TQ_ADDR_MODE_CUR: mode_cur_q <= reg_wdata_i[7:0];
          `TQ_ADDR_MODE_SAVED: mode_saved_q <= reg_wdata_i[7:0];
          `TQ_ADDR_MODE_DEFAULT: mode_default_q <= reg_wdata_i[7:0];
          `TQ_ADDR_RESV: resv_q <= reg_wdata_i[INIT_N-1:0];
          default: begin
          end
        endcase
      end

      // register reads, data valid one cycle later
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `TQ_ADDR_CTRL: reg_rdata_o <= {28'h0000000, ca_q, mode_saved_valid_q, 1'b0, tagged_mode_q};
          `TQ_ADDR_STATUS: reg_rdata_o <= {16'h0000, {(8-IDX_W-1){1'b0}}, cnt_q,
                                            5'h00, busy_exec_q, st_q};
          `TQ_ADDR_MODE_CUR: reg_rdata_o <= {24'h000000, mode_cur_q};
          `TQ_ADDR_MODE_SAVED: reg_rdata_o <= {24'h000000, mode_saved_q};
          `TQ_ADDR_MODE_DEFAULT: reg_rdata_o <= {24'h000000, mode_default_q};
          `TQ_ADDR_UA: reg_rdata_o <= {{(32-INIT_N){1'b0}}, ua_q};
          `TQ_ADDR_SENSE: reg_rdata_o <= {16'h0000, {(4-INIT_W){1'b0}}, sense_init_q, sense_key_q, sense_asc_q};
          `TQ_ADDR_RESV: reg_rdata_o <= {{(32-INIT_N){1'b0}}, resv_q};
          `TQ_ADDR_PARAM: reg_rdata_o <= {24'h000000, param_last_q};
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end

      // per initiator flag, cleared by that one only
      if (ua_clr) begin
        ua_q <= ua_q & ~ini_bit;
      end

      // execution engine
      if (exec_done_i) begin
        busy_exec_q <= 1'b0;
        if (cmd_check_i) begin
          ca_q <= 1'b1;
          ca_init_q <= run_init_q;
        end
      end

      if (deferred_err_i) begin
        deferred_valid_o <= 1'b1;
        deferred_init_o <= deferred_init_i;
        deferred_tag_o <= {TAG_W{1'b0}};
      end

      if (issue) begin
        busy_exec_q <= 1'b1;
        run_init_q <= qi_q[0];
        exec_init_o <= qi_q[0];
        exec_tag_o <= qt_q[0];
        exec_tagged_o <= (qa_q[0] != `TQ_ATTR_UNTAGGED);
      end

      // admission answer
      if (cmd_valid_i) begin
        resp_valid_o <= 1'b1;
        resp_init_o <= cmd_init_i;
        resp_param_o <= cmd_param_i;
        resp_status_o <= `TQ_STAT_GOOD;
        if (busy) begin
          resp_status_o <= `TQ_STAT_BUSY;
        end else if (overlap) begin
          resp_status_o <= `TQ_STAT_CHECK;
          sense_key_q <= `TQ_KEY_ABORTED;
          sense_asc_q <= `TQ_ASC_OVERLAP;
          sense_init_q <= cmd_init_i;
        end else if (p_bad && !round_en) begin
          resp_status_o <= `TQ_STAT_CHECK;
          sense_key_q <= `TQ_KEY_ILLEGAL;
          sense_asc_q <= `TQ_ASC_INVALID_PARAM;
          sense_init_q <= cmd_init_i;
        end else if (p_bad) begin
          resp_status_o <= `TQ_STAT_CHECK;
          resp_param_o <= p_round;
          param_last_q <= p_round;
          sense_key_q <= `TQ_KEY_RECOVERED;
          sense_asc_q <= `TQ_ASC_ROUNDED;
          sense_init_q <= cmd_init_i;
        end else if (cmd_has_param_i) begin
          param_last_q <= cmd_param_i;
        end
      end

      // queue update: pop slot 0, then insert
      begin : qupd
        reg [DEPTH-1:0] nv;
        reg [INIT_W-1:0] ni [0:DEPTH-1];
        reg [TAG_W-1:0] nt [0:DEPTH-1];
        reg [1:0] na [0:DEPTH-1];
        integer j;
        reg [IDX_W:0] c;
        nv = v_q;
        c = cnt_q;
        for (j = 0; j < DEPTH; j = j + 1) begin
          ni[j] = qi_q[j];
          nt[j] = qt_q[j];
          na[j] = qa_q[j];
        end
        if (issue) begin
          for (j = 0; j < DEPTH - 1; j = j + 1) begin
            nv[j] = nv[j+1];
            ni[j] = ni[j+1];
            nt[j] = nt[j+1];
            na[j] = na[j+1];
          end
          nv[DEPTH-1] = 1'b0;
          c = c - 1'b1;
        end
        if (overlap) begin
          for (j = 0; j < DEPTH; j = j + 1) begin
            if (nv[j] && ni[j] == cmd_init_i) begin
              nv[j] = 1'b0;
            end
          end
          if (running_same) begin
            exec_abort_o <= 1'b1;
            busy_exec_q <= 1'b0;
          end
          // recompact
          c = {(IDX_W+1){1'b0}};
          for (j = 0; j < DEPTH; j = j + 1) begin
            if (nv[j]) begin
              ni[c[IDX_W-1:0]] = ni[j];
              nt[c[IDX_W-1:0]] = nt[j];
              na[c[IDX_W-1:0]] = na[j];
              c = c + 1'b1;
            end
          end
          for (j = 0; j < DEPTH; j = j + 1) begin
            nv[j] = (j < c);
          end
        end
        if (accept) begin
          if (cmd_attr_i == `TQ_ATTR_HEAD) begin
            for (j = DEPTH - 1; j > 0; j = j - 1) begin
              nv[j] = nv[j-1];
              ni[j] = ni[j-1];
              nt[j] = nt[j-1];
              na[j] = na[j-1];
            end
            nv[0] = 1'b1;
            ni[0] = cmd_init_i;
            nt[0] = cmd_tag_i;
            na[0] = cmd_attr_i;
          end else begin
            nv[c[IDX_W-1:0]] = 1'b1;
            ni[c[IDX_W-1:0]] = cmd_init_i;
            nt[c[IDX_W-1:0]] = cmd_tag_i;
            na[c[IDX_W-1:0]] = cmd_attr_i;
          end
          c = c + 1'b1;
        end
        // abort every task on unit reset
        if (st_q == ST_ABORT) begin
          nv = {DEPTH{1'b0}};
          c = {(IDX_W+1){1'b0}};
        end
        v_q <= nv;
        cnt_q <= c;
        for (j = 0; j < DEPTH; j = j + 1) begin
          qi_q[j] <= ni[j];
          qt_q[j] <= nt[j];
          qa_q[j] <= na[j];
        end
      end

      // ********************************************************
      // logical unit reset sequence
      // ********************************************************
      case (st_q)
        ST_IDLE: begin
          if (hard_rst || lu_rst) begin
            st_q <= ST_ABORT;
          end
        end
        ST_ABORT: begin
          if (busy_exec_q) begin
            exec_abort_o <= 1'b1;
          end
          busy_exec_q <= 1'b0;
          ca_q <= 1'b0;
          resv_q <= {INIT_N{1'b0}};
          st_q <= ST_MODE;
        end
        ST_MODE: begin
          mode_cur_q <= mode_saved_valid_q ? mode_saved_q : mode_default_q;
          st_q <= ST_FINISH;
        end
        ST_FINISH: begin
          ua_q <= {INIT_N{1'b1}};
          sense_key_q <= `TQ_KEY_UNIT_ATTN;
          sense_asc_q <= `TQ_ASC_RESET;
          nested_reset_o <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

/* include/task_queue_defines.vh */
// constants for the target task queue and reset sequencer
`ifndef TASK_QUEUE_DEFINES_VH
`define TASK_QUEUE_DEFINES_VH
// register indices, word addressed on the plain port
`define TQ_ADDR_CTRL 4'h0
`define TQ_ADDR_STATUS 4'h1
`define TQ_ADDR_MODE_CUR 4'h2
`define TQ_ADDR_MODE_SAVED 4'h3
`define TQ_ADDR_MODE_DEFAULT 4'h4
`define TQ_ADDR_UA 4'h5
`define TQ_ADDR_SENSE 4'h6
`define TQ_ADDR_RESV 4'h7
`define TQ_ADDR_PARAM 4'h8
// ctrl fields
`define TQ_CTRL_TAGGED 0
`define TQ_CTRL_HARD_RST 1
`define TQ_CTRL_LU_RST 2
`define TQ_CTRL_MODE_SAVED_VALID 3
`define TQ_CTRL_CA_CLEAR 4
// mode page 00h byte 2: bit 2 enables rounding
`define TQ_MODE_ROUND_BIT 2
`define TQ_MODE_RESET 8'h00
// task attributes
`define TQ_ATTR_UNTAGGED 2'h0
`define TQ_ATTR_SIMPLE 2'h1
`define TQ_ATTR_ORDERED 2'h2
`define TQ_ATTR_HEAD 2'h3
// status codes
`define TQ_STAT_GOOD 8'h00
`define TQ_STAT_CHECK 8'h02
`define TQ_STAT_BUSY 8'h08
// sense keys and additional sense codes
`define TQ_KEY_NONE 4'h0
`define TQ_KEY_RECOVERED 4'h1
`define TQ_KEY_ILLEGAL 4'h5
`define TQ_KEY_UNIT_ATTN 4'h6
`define TQ_KEY_ABORTED 4'hB
`define TQ_ASC_NONE 8'h00
`define TQ_ASC_ROUNDED 8'h37
`define TQ_ASC_INVALID_PARAM 8'h26
`define TQ_ASC_OVERLAP 8'h4E
`define TQ_ASC_RESET 8'h29
`endif

/* tb/initiator_model.sv */
// initiator ports on the shared bus, handing new tasks to the target
`timescale 1ns/100ps
module initiator_model #(
  parameter INIT_W = 2,
  parameter TAG_W = 8
) (
  input wire clk_i,
  output reg cmd_valid_o,
  output reg [INIT_W-1:0] cmd_init_o,
  output reg [1:0] cmd_attr_o,
  output reg [TAG_W-1:0] cmd_tag_o,
  output reg cmd_disc_o,
  output reg cmd_clears_ua_o,
  output reg cmd_has_param_o,
  output reg [7:0] cmd_param_o,
  output reg cmd_param_max_o,
  output reg cmd_param_round_ok_o
);
  // ****************************************
  // task issue
  // ****************************************
  initial begin
    {cmd_valid_o, cmd_init_o, cmd_attr_o, cmd_tag_o, cmd_disc_o} = '0;
    {cmd_clears_ua_o, cmd_has_param_o, cmd_param_o, cmd_param_max_o, cmd_param_round_ok_o} = '0;
  end
  // one untagged per nexus: callers repeat one only to provoke a refusal
  task send(input [INIT_W-1:0] i, input [1:0] a, input [TAG_W-1:0] t, input d, input u,
            input hp, input [7:0] p, input mx, input ok);
    begin
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      {cmd_init_o, cmd_attr_o, cmd_tag_o, cmd_disc_o, cmd_clears_ua_o} <= {i, a, t, d, u};
      {cmd_has_param_o, cmd_param_o, cmd_param_max_o, cmd_param_round_ok_o} <= {hp, p, mx, ok};
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      // stale qualifiers must not look valid between tasks
      cmd_tag_o <= ~t;
      cmd_param_o <= ~p;
    end
  endtask
endmodule

/* tb/task_queue_chk.sv */
// assertion checker for the target task queue ports
`timescale 1ns/100ps
`include "task_queue_defines.vh"
module task_queue_chk #(
  parameter INIT_W = 2,
  parameter TAG_W = 8
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_attr_i,
  input wire cmd_disc_i,
  input wire cmd_has_param_i,
  input wire [7:0] cmd_param_i,
  input wire resp_valid_o,
  input wire [7:0] resp_status_o,
  input wire exec_abort_o,
  input wire deferred_err_i,
  input wire [INIT_W-1:0] deferred_init_i,
  input wire deferred_valid_o,
  input wire [INIT_W-1:0] deferred_init_o,
  input wire [TAG_W-1:0] deferred_tag_o,
  input wire nested_reset_o,
  input wire queue_full_o
);
  // ****************************************
  // properties, all in the one clock domain
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_resp_after_cmd: assert property (cmd_valid_i |=> resp_valid_o)
    else $error("no response one cycle after a task");
  a_resp_has_cause: assert property (resp_valid_o |-> $past(cmd_valid_i))
    else $error("response without a task");
  a_busy_no_disc: assert property (cmd_valid_i && !cmd_disc_i |=> resp_status_o == `TQ_STAT_BUSY)
    else $error("task without disconnect privilege not busy");
  a_busy_when_full: assert property (cmd_valid_i && queue_full_o && cmd_attr_i != `TQ_ATTR_UNTAGGED
    |=> resp_status_o == `TQ_STAT_BUSY)
    else $error("tagged task accepted into a full queue");
  a_param_not_good: assert property (cmd_valid_i && cmd_has_param_i && cmd_param_i[1:0] != 2'h0
    |=> resp_status_o != `TQ_STAT_GOOD)
    else $error("inexact parameter answered good");
  a_deferred_no_tag: assert property (deferred_err_i |=> deferred_valid_o && deferred_tag_o == 0
    && deferred_init_o == $past(deferred_init_i))
    else $error("deferred report wrong");
  a_reset_nests: assert property (reg_wr_i && reg_addr_i == `TQ_ADDR_CTRL
    && (reg_wdata_i[`TQ_CTRL_HARD_RST] || reg_wdata_i[`TQ_CTRL_LU_RST]) |-> ##[1:5] nested_reset_o)
    else $error("nested unit reset missing");
  a_nested_pulse: assert property ($rose(nested_reset_o) |=> $fell(nested_reset_o))
    else $error("nested reset not a single pulse");
  a_abort_pulse: assert property (exec_abort_o |=> !exec_abort_o)
    else $error("abort not a single pulse");
endmodule

bind task_queue_ctrl task_queue_chk #(.INIT_W(INIT_W), .TAG_W(TAG_W)) u_task_queue_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .cmd_valid_i(cmd_valid_i), .cmd_attr_i(cmd_attr_i), .cmd_disc_i(cmd_disc_i),
  .cmd_has_param_i(cmd_has_param_i), .cmd_param_i(cmd_param_i), .resp_valid_o(resp_valid_o),
  .resp_status_o(resp_status_o), .exec_abort_o(exec_abort_o), .deferred_err_i(deferred_err_i),
  .deferred_init_i(deferred_init_i), .deferred_valid_o(deferred_valid_o),
  .deferred_init_o(deferred_init_o), .deferred_tag_o(deferred_tag_o),
  .nested_reset_o(nested_reset_o), .queue_full_o(queue_full_o));

/* tb/testbench.sv */
// self-checking bench for the target task queue
`timescale 1ns/100ps
`include "task_queue_defines.vh"
module testbench;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [3:0] reg_addr_i = 4'h0;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, exec_ready_i = 1'b0, exec_done_i = 1'b0;
  reg cmd_check_i = 1'b0, deferred_err_i = 1'b0, abort_seen = 1'b0;
  reg [1:0] deferred_init_i = 2'h0;
  wire cmd_valid, cmd_disc, cmd_ua, cmd_hp, cmd_pmax, cmd_rok;
  wire [1:0] cmd_init, cmd_attr, resp_init_o, exec_init_o, deferred_init_o;
  wire [7:0] cmd_tag, cmd_param, resp_status_o, resp_param_o, exec_tag_o, deferred_tag_o;
  wire [31:0] reg_rdata_o;
  wire resp_valid_o, exec_valid_o, exec_tagged_o, exec_abort_o, deferred_valid_o, nested_reset_o, queue_full_o;
  integer seed, bad_count = 0, total_checks = 0, k, n;
  reg [31:0] d;
  reg [7:0] p, r;
  reg [1:0] ii [0:3];
  reg [7:0] tt [0:3];

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (exec_abort_o === 1'b1) abort_seen = 1'b1;

  initiator_model #(.INIT_W(2), .TAG_W(8)) u_initiator_model (.clk_i(clk_i), .cmd_valid_o(cmd_valid),
    .cmd_init_o(cmd_init), .cmd_attr_o(cmd_attr), .cmd_tag_o(cmd_tag), .cmd_disc_o(cmd_disc),
    .cmd_clears_ua_o(cmd_ua), .cmd_has_param_o(cmd_hp), .cmd_param_o(cmd_param),
    .cmd_param_max_o(cmd_pmax), .cmd_param_round_ok_o(cmd_rok));
  task_queue_ctrl #(.DEPTH(4), .IDX_W(2)) u_task_queue_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid), .cmd_init_i(cmd_init), .cmd_attr_i(cmd_attr),
    .cmd_tag_i(cmd_tag), .cmd_disc_i(cmd_disc), .cmd_clears_ua_i(cmd_ua), .cmd_has_param_i(cmd_hp),
    .cmd_param_i(cmd_param), .cmd_param_max_i(cmd_pmax), .cmd_param_round_ok_i(cmd_rok),
    .cmd_check_i(cmd_check_i), .resp_valid_o(resp_valid_o), .resp_status_o(resp_status_o),
    .resp_init_o(resp_init_o), .resp_param_o(resp_param_o), .exec_valid_o(exec_valid_o),
    .exec_ready_i(exec_ready_i), .exec_init_o(exec_init_o), .exec_tag_o(exec_tag_o),
    .exec_tagged_o(exec_tagged_o), .exec_done_i(exec_done_i), .exec_abort_o(exec_abort_o),
    .deferred_err_i(deferred_err_i), .deferred_init_i(deferred_init_i), .deferred_valid_o(deferred_valid_o),
    .deferred_init_o(deferred_init_o), .deferred_tag_o(deferred_tag_o), .nested_reset_o(nested_reset_o),
    .queue_full_o(queue_full_o));

  // ****************************************
  // helpers
  // ****************************************
  task final_report;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input ok, input [8*24-1:0] msg);
    begin
      total_checks = total_checks + 1;
      if (!ok) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t %0s", $time, msg);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rdchk(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
      chk((d & m) === e, "register value");
    end
  endtask
  task resp(input [7:0] st);
    begin
      #1 chk(resp_valid_o === 1'b1 && resp_status_o === st && resp_init_o === cmd_init, "task status");
    end
  endtask
  task cmd(input [1:0] i, input [1:0] a, input [7:0] t, input dc, input [7:0] st);
    begin
      u_initiator_model.send(i, a, t, dc, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
      resp(st);
    end
  endtask
  task run(input [1:0] i, input [7:0] t, input c, input fin);
    begin
      for (n = 0; n < 20 && exec_valid_o !== 1'b1; n = n + 1) @(negedge clk_i);
      if (n == 20) begin
        chk(1'b0, "no dispatch");
        final_report;
      end
      @(posedge clk_i) exec_ready_i <= 1'b1;
      @(posedge clk_i) exec_ready_i <= 1'b0;
      #1 chk(exec_tag_o === t && exec_init_o === i, "dispatch order");
      if (fin) begin
        @(posedge clk_i) {exec_done_i, cmd_check_i} <= {1'b1, c};
        @(posedge clk_i) {exec_done_i, cmd_check_i} <= 2'b00;
      end
    end
  endtask
  task wait_nested;
    begin
      for (n = 0; n < 8 && nested_reset_o !== 1'b1; n = n + 1) @(negedge clk_i);
      if (n == 8) begin
        chk(1'b0, "no nested reset");
        final_report;
      end
    end
  endtask
  function [7:0] rnd(input [7:0] v, input mx);
    rnd = mx ? (v & 8'hFC) : ((v | 8'h03) + 8'h01);
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 32'h3D75;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdchk(`TQ_ADDR_UA, 32'hF, 32'hF);
    wr(`TQ_ADDR_CTRL, 32'h0);
    u_initiator_model.send(0, `TQ_ATTR_UNTAGGED, 0, 1, 1, 0, 8'h00, 0, 0);
    resp(`TQ_STAT_GOOD);
    cmd(0, `TQ_ATTR_UNTAGGED, 0, 1, `TQ_STAT_BUSY);
    cmd(1, `TQ_ATTR_UNTAGGED, 0, 0, `TQ_STAT_BUSY);
    cmd(1, `TQ_ATTR_SIMPLE, 8'h05, 1, `TQ_STAT_BUSY);
    rdchk(`TQ_ADDR_UA, 32'hF, 32'hE);
    run(0, 8'h00, 0, 1);
    chk(exec_tagged_o === 1'b0, "untagged marked tagged");
    wr(`TQ_ADDR_CTRL, 32'h1);
    cmd(1, `TQ_ATTR_SIMPLE, 8'h11, 0, `TQ_STAT_BUSY);
    for (k = 0; k < 4; k = k + 1) begin
      ii[k] = 2'($random(seed));
      tt[k] = 8'($random(seed));
    end
    cmd(ii[0], `TQ_ATTR_SIMPLE, tt[0], 1, `TQ_STAT_GOOD);
    cmd(ii[1], `TQ_ATTR_HEAD, tt[1], 1, `TQ_STAT_GOOD);
    cmd(ii[2], `TQ_ATTR_HEAD, tt[2], 1, `TQ_STAT_GOOD);
    cmd(ii[3], `TQ_ATTR_ORDERED, tt[3], 1, `TQ_STAT_GOOD);
    chk(queue_full_o === 1'b1, "queue full");
    cmd(ii[0], `TQ_ATTR_SIMPLE, tt[0] + 8'h01, 1, `TQ_STAT_BUSY);
    run(ii[2], tt[2], 0, 1);
    chk(exec_tagged_o === 1'b1, "tag flag missing");
    run(ii[1], tt[1], 0, 1);
    run(ii[0], tt[0], 0, 1);
    run(ii[3], tt[3], 0, 1);
    cmd(2, `TQ_ATTR_SIMPLE, 8'h21, 1, `TQ_STAT_GOOD);
    cmd(1, `TQ_ATTR_SIMPLE, 8'h12, 1, `TQ_STAT_GOOD);
    run(2, 8'h21, 1, 1);
    #1 chk(exec_valid_o === 1'b0, "queue not suspended");
    cmd(3, `TQ_ATTR_SIMPLE, 8'h31, 1, `TQ_STAT_BUSY);
    wr(`TQ_ADDR_CTRL, 32'h11);
    run(1, 8'h12, 0, 1);
    cmd(1, `TQ_ATTR_SIMPLE, 8'h13, 1, `TQ_STAT_GOOD);
    run(1, 8'h13, 0, 0);
    cmd(1, `TQ_ATTR_SIMPLE, 8'h14, 1, `TQ_STAT_GOOD);
    abort_seen = 1'b0;
    cmd(1, `TQ_ATTR_UNTAGGED, 0, 1, `TQ_STAT_CHECK);
    repeat (2) @(posedge clk_i);
    #1 chk(abort_seen === 1'b1 && exec_valid_o === 1'b0, "initiator not flushed");
    rdchk(`TQ_ADDR_SENSE, 32'hFFF, {20'h0, `TQ_KEY_ABORTED, `TQ_ASC_OVERLAP});
    cmd(2, `TQ_ATTR_UNTAGGED, 0, 1, `TQ_STAT_GOOD);
    cmd(2, `TQ_ATTR_SIMPLE, 8'h22, 1, `TQ_STAT_CHECK);
    #1 chk(exec_valid_o === 1'b0, "untagged not flushed");
    p = (8'($random(seed)) & 8'h7C) | 8'h01;
    u_initiator_model.send(3, `TQ_ATTR_SIMPLE, 8'h33, 1, 0, 1, p, 1, 1);
    resp(`TQ_STAT_CHECK);
    rdchk(`TQ_ADDR_SENSE, 32'hFFF, {20'h0, `TQ_KEY_ILLEGAL, `TQ_ASC_INVALID_PARAM});
    wr(`TQ_ADDR_MODE_CUR, 32'h4);
    for (k = 0; k < 2; k = k + 1) begin
      p = (8'($random(seed)) & 8'h7C) | 8'h02;
      u_initiator_model.send(3, `TQ_ATTR_SIMPLE, 8'h34, 1, 0, 1, p, k[0], 1);
      resp(`TQ_STAT_CHECK);
      chk(resp_param_o === rnd(p, k[0]), "rounded value");
      rdchk(`TQ_ADDR_SENSE, 32'hFFF, {20'h0, `TQ_KEY_RECOVERED, `TQ_ASC_ROUNDED});
      rdchk(`TQ_ADDR_PARAM, 32'hFF, {24'h0, rnd(p, k[0])});
    end
    @(posedge clk_i) {deferred_err_i, deferred_init_i} <= {1'b1, 2'($random(seed))};
    @(posedge clk_i) deferred_err_i <= 1'b0;
    #1 chk(deferred_valid_o === 1'b1 && deferred_tag_o === 8'h00 && deferred_init_o === deferred_init_i,
      "deferred report");
    cmd(0, `TQ_ATTR_ORDERED, 8'h01, 1, `TQ_STAT_GOOD);
    wr(`TQ_ADDR_RESV, 32'hF);
    r = 8'($random(seed));
    wr(`TQ_ADDR_MODE_SAVED, {24'h0, r});
    wr(`TQ_ADDR_CTRL, 32'hD);
    wait_nested;
    rdchk(`TQ_ADDR_MODE_CUR, 32'hFF, {24'h0, r});
    rdchk(`TQ_ADDR_UA, 32'hF, 32'hF);
    rdchk(`TQ_ADDR_RESV, 32'hFFFFFFFF, 32'h0);
    chk(exec_valid_o === 1'b0, "task set not aborted");
    wr(`TQ_ADDR_MODE_DEFAULT, {24'h0, ~r});
    wr(`TQ_ADDR_CTRL, 32'h2);
    wait_nested;
    rdchk(`TQ_ADDR_MODE_CUR, 32'hFF, {24'h0, ~r});
    final_report;
  end
endmodule
